// ==== hdl/mgmt_front.v ====
// Decided for this implementation: register access over APB and the register addresses.
`timescale 1ns/10ps
`include "mgmt_map.vh"
module mgmt_front #(
	parameter HALF_DUPLEX_CAPABLE = 1,
	parameter GAP_W               = 8,
	parameter [7:0] MIN_GAP       = 8'h0c
) (
	// Clock and reset
	input  wire              core_clk_in,
	input  wire              reset_in,
	// APB slave
	input  wire              psel_in,
	input  wire              penable_in,
	input  wire              pwrite_in,
	input  wire [7:0]        paddr_in,
	input  wire [31:0]       pwdata_in,
	output reg  [31:0]       prdata_out,
	output reg               pready_out,
	output reg               pslverr_out,
	// Serial management pins
	output reg               mdc_out,
	output reg               mdio_out,
	output reg               mdio_oe_n_out,
	input  wire              mdio_in,
	output reg               serial_mgmt_ready_out,
	// Configuration vector and frame engine status
	input  wire [63:0]       config_vector_in,
	input  wire              rx_frame_busy_in,
	input  wire              tx_frame_busy_in,
	input  wire [GAP_W-1:0]  gap_delay_input_in,
	input  wire              pause_req_in,
	input  wire              rx_pause_frame_in,
	// Decoded configuration
	output reg  [47:0]       pause_addr_out,
	output reg               rx_half_duplex_out,
	output reg               rx_vlan_en_out,
	output reg               rx_enable_out,
	output reg               rx_fcs_pass_out,
	output reg               rx_jumbo_en_out,
	output reg               rx_reset_out,
	output reg               rx_lt_check_dis_out,
	output reg  [GAP_W-1:0]  tx_gap_out,
	output reg               tx_half_duplex_out,
	output reg               tx_vlan_en_out,
	output reg               tx_enable_out,
	output reg               tx_client_fcs_out,
	output reg               tx_jumbo_en_out,
	output reg               tx_reset_out,
	output reg               tx_pause_send_out,
	output reg               rx_pause_inhibit_out,
	output reg               rx_pause_to_client_out
);

	// ----------------------------------------
	// States and decode helpers
	// ----------------------------------------
	localparam ST_IDLE = 1'b0;
	localparam ST_BUSY = 1'b1;

	// Only the read opcode hands the data pin to the PHY
	function is_read_op;
		input [1:0] op;
		begin
			is_read_op = (op == `OP_READ);
		end
	endfunction

	// Whole frame, first bit on the wire in the top position
	function [63:0] frame_word;
		input [11:0] hdr;
		input [15:0] data;
		begin
			frame_word = {`PREAMBLE, `START_CODE,
				hdr[11:10],
				hdr[9:5], hdr[4:0],
				`TA_WRITE, data};
		end
	endfunction

	// Configuration bits allowed to move in this cycle
	function [63:0] cfg_update_mask;
		input rx_busy;
		input tx_busy;
		begin
			cfg_update_mask = `CFG_NOW_MASK;
			if (!rx_busy)
				cfg_update_mask = cfg_update_mask | `CFG_RX_MASK;
			if (!tx_busy)
				cfg_update_mask = cfg_update_mask | `CFG_TX_MASK;
		end
	endfunction

	// ----------------------------------------
	// Address decode
	// ----------------------------------------

	function is_mapped;
		input [7:0] a;
		begin
			is_mapped = (a == `OFS_CTRL) || (a == `OFS_CMD) || (a == `OFS_WDATA) ||
				(a == `OFS_STATUS) || (a == `OFS_RDATA) || (a == `OFS_CFG_LO) ||
				(a == `OFS_CFG_HI);
		end
	endfunction

	// ----------------------------------------
	// Register bus
	// ----------------------------------------
	reg  [4:0]  clk_div;
	reg         mdio_en;
	reg  [11:0] cmd;
	reg  [15:0] wr_data;
	reg  [15:0] rd_data;
	reg  [63:0] cfg;
	reg         state;
	reg  [31:0] next_rdata;
	wire        setup = psel_in & ~penable_in;
	wire        wr_go = psel_in & penable_in & pready_out & pwrite_in;
	wire        cmd_hit = wr_go && (paddr_in == `OFS_CMD);
	wire        start = cmd_hit && (state == ST_IDLE) && mdio_en;

	// ----------------------------------------
	// Read data selection
	// ----------------------------------------
	always @* begin
		case (paddr_in)
			`OFS_CTRL:   next_rdata = {26'h0, mdio_en, clk_div};
			`OFS_CMD:    next_rdata = {20'h0, cmd};
			`OFS_WDATA:  next_rdata = {16'h0, wr_data};
			`OFS_STATUS: next_rdata = {30'h0, mdio_en, serial_mgmt_ready_out};
			`OFS_RDATA:  next_rdata = {16'h0, rd_data};
			`OFS_CFG_LO: next_rdata = cfg[31:0];
			`OFS_CFG_HI: next_rdata = cfg[63:32];
			default:     next_rdata = 32'h0000_0000;
		endcase
	end

	// ----------------------------------------
	// Bus response
	// ----------------------------------------
	// Zero-wait slave: data is fetched in setup so pready can stand registered
	always @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			prdata_out  <= 32'h0000_0000;
			pready_out  <= 1'b0;
			pslverr_out <= 1'b0;
		end else begin
			pready_out  <= setup;
			pslverr_out <= setup & ~is_mapped(paddr_in);
			prdata_out  <= (setup & ~pwrite_in) ? next_rdata : 32'h0000_0000;
		end
	end

	// ----------------------------------------
	// Control registers
	// ----------------------------------------
	always @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			clk_div <= 5'h00;
			mdio_en <= 1'b0;
			cmd     <= 12'h000;
			wr_data <= 16'h0000;
		end else if (wr_go) begin
			// Divide frozen mid-frame so the serial clock period never jumps
			if (paddr_in == `OFS_CTRL && state == ST_IDLE) begin
				clk_div <= pwdata_in[`CTRL_DIV_MSB:0];
				// Enable refused while divide is zero, so MDC never overspeeds
				mdio_en <= pwdata_in[`CTRL_EN_BIT] && (pwdata_in[`CTRL_DIV_MSB:0] != 5'h00);
			end
			// Command only moves between frames
			if (paddr_in == `OFS_CMD && state == ST_IDLE)
				cmd <= pwdata_in[11:0];
			if (paddr_in == `OFS_WDATA)
				wr_data <= pwdata_in[15:0];
		end
	end

	// ----------------------------------------
	// Serial management master
	// ----------------------------------------
	reg  [4:0]  div_cnt;
	reg  [5:0]  bit_cnt;
	reg  [63:0] shift;
	reg  [15:0] rx_shift;
	reg         is_read;
	wire        tick = (div_cnt == clk_div);
	wire        ta_up = is_read && (bit_cnt >= `TA_FIRST);

	// ----------------------------------------
	// Serial clock divider
	// ----------------------------------------
	// Held at zero between frames so each frame opens on a full half period
	always @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in)
			div_cnt <= 5'h00;
		else if (state != ST_BUSY || tick)
			div_cnt <= 5'h00;
		else
			div_cnt <= div_cnt + 5'h01;
	end

	// ----------------------------------------
	// Frame sequencer
	// ----------------------------------------

	always @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			state                 <= ST_IDLE;
			rx_shift              <= 16'h0000;
			bit_cnt               <= 6'h00;
			shift                 <= 64'h0;
			is_read               <= 1'b0;
			rd_data               <= 16'h0000;
			mdc_out               <= 1'b0;
			mdio_out              <= 1'b1;
			mdio_oe_n_out         <= 1'b1;
			serial_mgmt_ready_out <= 1'b1;
		end else begin
			case (state)
				ST_IDLE: begin
					mdc_out       <= 1'b0;
					mdio_oe_n_out <= 1'b1;
					// A request while busy never reaches here
					if (start) begin
						state                 <= ST_BUSY;
						serial_mgmt_ready_out <= 1'b0;
						is_read               <= is_read_op(pwdata_in[11:10]);
						bit_cnt               <= 6'h00;
						shift                 <= frame_word(pwdata_in[11:0], wr_data);
						mdio_out              <= 1'b1;
						mdio_oe_n_out         <= 1'b0;
					end
				end
				ST_BUSY: begin
					if (tick) begin
						mdc_out <= ~mdc_out;
						// Rising serial edge: PHY data is taken
						if (!mdc_out) begin
							if (ta_up && bit_cnt >= `DATA_FIRST)
								rx_shift <= {rx_shift[14:0], mdio_in};
						end else if (bit_cnt == `FRAME_LAST) begin
							state                 <= ST_IDLE;
							mdio_oe_n_out         <= 1'b1;
							serial_mgmt_ready_out <= 1'b1;
							// Read data swaps in whole, never half shifted
							if (is_read)
								rd_data <= rx_shift;
						end else begin
							bit_cnt       <= bit_cnt + 6'h01;
							shift         <= {shift[62:0], 1'b0};
							mdio_out      <= shift[62];
							// Turnaround onward belongs to the PHY on reads
							mdio_oe_n_out <= is_read && (bit_cnt + 6'h01 >= `TA_FIRST);
						end
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Configuration vector
	// ----------------------------------------
	reg  [63:0] cfg_s1;
	reg  [63:0] cfg_s2;
	wire [63:0] upd     = cfg_update_mask(rx_frame_busy_in, tx_frame_busy_in);
	wire        hd_ok   = (HALF_DUPLEX_CAPABLE != 0);

	// ----------------------------------------
	// Synchroniser and deferred apply
	// ----------------------------------------
	// Bits are synchronised one by one; a word that changes skewed may tear for a cycle

	always @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			cfg_s1 <= 64'h0;
			cfg_s2 <= 64'h0;
			cfg    <= 64'h0;
		end else begin
			cfg_s1 <= config_vector_in;
			cfg_s2 <= cfg_s1;
			cfg    <= (cfg & ~upd) | (cfg_s2 & upd);
		end
	end

	// ----------------------------------------
	// Receive side outputs
	// ----------------------------------------
	always @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			pause_addr_out         <= 48'h0;
			rx_half_duplex_out     <= 1'b0;
			rx_vlan_en_out         <= 1'b0;
			rx_enable_out          <= 1'b0;
			rx_fcs_pass_out        <= 1'b0;
			rx_jumbo_en_out        <= 1'b0;
			rx_reset_out           <= 1'b1;
			rx_lt_check_dis_out    <= 1'b0;
			rx_pause_inhibit_out   <= 1'b0;
			rx_pause_to_client_out <= 1'b0;
		end else begin
			pause_addr_out         <= cfg[47:0];
			rx_half_duplex_out     <= hd_ok & cfg[`CB_RX_HALF];
			rx_vlan_en_out         <= cfg[`CB_RX_VLAN];
			rx_enable_out          <= cfg[`CB_RX_EN];
			rx_fcs_pass_out        <= cfg[`CB_RX_FCS];
			rx_jumbo_en_out        <= cfg[`CB_RX_JUMBO];
			rx_reset_out           <= cfg[`CB_RX_RST];
			rx_lt_check_dis_out    <= cfg[`CB_LT_DIS];
			// Pause frames go to the inhibit or to the client, never both
			rx_pause_inhibit_out   <= rx_pause_frame_in & cfg[`CB_RX_FC];
			rx_pause_to_client_out <= rx_pause_frame_in & ~cfg[`CB_RX_FC];
		end
	end

	// ----------------------------------------
	// Transmit side outputs
	// ----------------------------------------
	always @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			tx_gap_out             <= MIN_GAP[GAP_W-1:0];
			tx_half_duplex_out     <= 1'b0;
			tx_vlan_en_out         <= 1'b0;
			tx_enable_out          <= 1'b0;
			tx_client_fcs_out      <= 1'b0;
			tx_jumbo_en_out        <= 1'b0;
			tx_reset_out           <= 1'b1;
			tx_pause_send_out      <= 1'b0;
		end else begin
			// Minimum gap unless the adjust bit hands it to the port
			tx_gap_out             <= cfg[`CB_TX_GAP] ? gap_delay_input_in
				: MIN_GAP[GAP_W-1:0];
			tx_half_duplex_out     <= hd_ok & cfg[`CB_TX_HALF];
			tx_vlan_en_out         <= cfg[`CB_TX_VLAN];
			tx_enable_out          <= cfg[`CB_TX_EN];
			tx_client_fcs_out      <= cfg[`CB_TX_FCS];
			tx_jumbo_en_out        <= cfg[`CB_TX_JUMBO];
			tx_reset_out           <= cfg[`CB_TX_RST];
			tx_pause_send_out      <= pause_req_in & cfg[`CB_TX_FC];
		end
	end

endmodule // mgmt_front

// ==== hdl/mgmt_map.vh ====
`ifndef MGMT_MAP_VH
`define MGMT_MAP_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_CTRL      8'h00
`define OFS_CMD       8'h04
`define OFS_WDATA     8'h08
`define OFS_STATUS    8'h0c
`define OFS_RDATA     8'h10
`define OFS_CFG_LO    8'h14
`define OFS_CFG_HI    8'h18
// ----------------------------------------
// Fields
// ----------------------------------------
`define CTRL_DIV_MSB  4
`define CTRL_EN_BIT   5
`define CMD_ADDR_MSB  9
`define CMD_OP_LSB    10
`define CTRL_RESET    32'h0000_0000
// ----------------------------------------
// Serial frame
// ----------------------------------------
`define OP_READ       2'h2
`define FRAME_LAST    6'h3f
`define TA_FIRST      6'h2e
`define DATA_FIRST    6'h30
`define PREAMBLE      32'hffff_ffff
`define START_CODE    2'h1
`define TA_WRITE      2'h2
// ----------------------------------------
// Configuration vector
// ----------------------------------------
`define CFG_RX_MASK   64'h801f_ffff_ffff_ffff
`define CFG_TX_MASK   64'h0fc0_0000_0000_0000
`define CFG_NOW_MASK  64'h7020_0000_0000_0000
`define CB_RX_HALF    48
`define CB_RX_VLAN    49
`define CB_RX_EN      50
`define CB_RX_FCS     51
`define CB_RX_JUMBO   52
`define CB_RX_RST     53
`define CB_TX_GAP     54
`define CB_TX_HALF    55
`define CB_TX_VLAN    56
`define CB_TX_EN      57
`define CB_TX_FCS     58
`define CB_TX_JUMBO   59
`define CB_TX_RST     60
`define CB_TX_FC      61
`define CB_RX_FC      62
`define CB_LT_DIS     63
`endif

// ==== tb/mgmt_front_checker.sv ====
`timescale 1ns/10ps
`include "mgmt_map.vh"
module mgmt_front_checker (
	// Clock, reset and bus
	input wire        core_clk_in,
	input wire        reset_in,
	input wire        psel_in,
	input wire        penable_in,
	input wire        pwrite_in,
	input wire [7:0]  paddr_in,
	input wire        pready_out,
	// Serial side and configuration
	input wire        mdc_out,
	input wire        mdio_oe_n_out,
	input wire        serial_mgmt_ready_out,
	input wire [63:0] config_vector_in,
	input wire        rx_frame_busy_in,
	input wire        tx_frame_busy_in,
	input wire        rx_enable_out,
	input wire        tx_enable_out,
	input wire        rx_reset_out,
	input wire        tx_reset_out
);
	reg [8:0] busy_len;
	reg [2:0] since;
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (reset_in);
	// ----------------------------------------
	// Helper counters
	// ----------------------------------------
	// Saturate so a stuck transfer cannot wrap back into range
	always @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			busy_len <= 9'h0;
			since <= 3'h0;
		end else begin
			busy_len <= serial_mgmt_ready_out ? 9'h0 : busy_len + {8'h0, busy_len != 9'h1ff};
			since <= since + {2'h0, since != 3'h7};
		end
	end
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	ready_fall_a: assert property ($fell(serial_mgmt_ready_out) |->
		$past(psel_in && penable_in && pwrite_in && paddr_in == `OFS_CMD)) else $error("ready fell without command");
	frame_len_a: assert property ($rose(serial_mgmt_ready_out) |-> busy_len >= 9'hff)
		else $error("transfer shorter than a frame");
	mdc_idle_a: assert property (serial_mgmt_ready_out |-> !mdc_out)
		else $error("serial clock runs while idle");
	oe_idle_a: assert property (serial_mgmt_ready_out |-> mdio_oe_n_out)
		else $error("data pin driven while idle");
	start_drive_a: assert property ($fell(serial_mgmt_ready_out) |-> !mdio_oe_n_out ##1 !mdio_oe_n_out)
		else $error("preamble not driven");
	rx_hold_a: assert property (since > 3'h2 && $past(rx_frame_busy_in) && $past(rx_frame_busy_in, 2)
		|-> $stable(rx_enable_out)) else $error("receive setting changed mid frame");
	tx_hold_a: assert property (since > 3'h2 && $past(tx_frame_busy_in) && $past(tx_frame_busy_in, 2)
		|-> $stable(tx_enable_out)) else $error("transmit setting changed mid frame");
	now_path_a: assert property (since == 3'h7 |-> {tx_reset_out, rx_reset_out} ==
		$past({config_vector_in[`CB_TX_RST], config_vector_in[`CB_RX_RST]}, 4)) else $error("reset bits late");
	acc_phase_a: assert property (pready_out |-> psel_in && penable_in && $past(psel_in && !penable_in))
		else $error("ready outside access phase");
	cover property ($rose(serial_mgmt_ready_out));
	cover property (rx_frame_busy_in && !$stable(config_vector_in));
	cover property (pready_out && pwrite_in);
endmodule // mgmt_front_checker
bind mgmt_front mgmt_front_checker u_mgmt_front_checker (.*);

// ==== tb/mgmt_front_test.sv ====
`timescale 1ns/10ps
`include "mgmt_map.vh"
module mgmt_front_test;
	logic        core_clk_in = 0, reset_in = 1, psel_in = 0, penable_in = 0, pwrite_in = 0;
	logic        rx_frame_busy_in = 0, tx_frame_busy_in = 0, pause_req_in = 1, rx_pause_frame_in = 1;
	logic [7:0]  paddr_in = 8'h0, gap_delay_input_in = 8'h21;
	logic [31:0] pwdata_in = 32'h0, rq;
	logic [63:0] config_vector_in = 64'h0;
	wire  [31:0] prdata_out;
	wire  [47:0] pause_addr_out;
	wire  [7:0]  tx_gap_out;
	wire  [11:0] hdr;
	wire         pready_out, pslverr_out, mdc_out, mdio_out, mdio_oe_n_out, mdio_in;
	wire         serial_mgmt_ready_out, rx_half_duplex_out, rx_vlan_en_out, rx_enable_out;
	wire         rx_fcs_pass_out, rx_jumbo_en_out, rx_reset_out, rx_lt_check_dis_out, tx_half_duplex_out;
	wire         tx_vlan_en_out, tx_enable_out, tx_client_fcs_out, tx_jumbo_en_out, tx_reset_out;
	wire         tx_pause_send_out, rx_pause_inhibit_out, rx_pause_to_client_out;
	logic        re;
	integer      err_total = 0, n_compared = 0;
	localparam [63:0] V1 = 64'hb5a5_0123_4567_89ab, V2 = 64'h4a5a_fedc_ba98_7654;
	mgmt_front u_mgmt_front (.*);
	phy_model u_phy_model (.mdc_in(mdc_out), .pin_d_in(mdio_out), .pin_oe_n_in(mdio_oe_n_out),
		.pin_out(mdio_in), .hdr_out(hdr));
	initial forever #12.5 core_clk_in = ~core_clk_in;
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wrap_up;
		$display("errors %0d compared %0d", err_total, n_compared);
		if (err_total == 0 && n_compared > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		integer n;
		n = 0;
		@(posedge core_clk_in);
		psel_in <= 1'b1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge core_clk_in);
		penable_in <= 1'b1;
		// Request stands until pready is seen high at a rising edge
		@(posedge core_clk_in);
		while (pready_out !== 1'b1 && n < 20) begin
			n++;
			@(posedge core_clk_in);
		end
		rq = prdata_out;
		re = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
		chk(n < 20, 1'b1);
		if (n >= 20) wrap_up;
	endtask
	// Divide 7 keeps the serial clock at 2.5 MHz, 16 host clocks a period
	task automatic mcmd(input logic [1:0] op, input logic [4:0] ph, input logic [4:0] rg, input logic [15:0] wd);
		integer n;
		time t;
		n = 0;
		apb(1'b1, `OFS_WDATA, {16'h0, wd});
		apb(1'b1, `OFS_CMD, {20'h0, op, ph, rg});
		@(negedge core_clk_in);
		chk(serial_mgmt_ready_out, 1'b0);
		@(posedge mdc_out);
		t = $time;
		@(posedge mdc_out);
		chk($time - t, 64'd400);
		apb(1'b1, `OFS_CMD, {20'h0, ~op, ph, ~rg});
		while (serial_mgmt_ready_out !== 1'b1 && n < 3000) begin
			n++;
			@(negedge core_clk_in);
		end
		chk(n < 3000, 1'b1);
		if (n >= 3000) wrap_up;
		chk(hdr, {op, ph, rg});
	endtask
	task automatic cfg_chk(input logic [63:0] v);
		chk({rx_lt_check_dis_out, tx_reset_out, tx_jumbo_en_out, tx_client_fcs_out, tx_enable_out,
			tx_vlan_en_out, tx_half_duplex_out, rx_reset_out, rx_jumbo_en_out, rx_fcs_pass_out,
			rx_enable_out, rx_vlan_en_out, rx_half_duplex_out, pause_addr_out}, {v[63], v[60:55], v[53:0]});
		chk({tx_gap_out, tx_pause_send_out, rx_pause_inhibit_out, rx_pause_to_client_out},
			{v[54] ? 8'h21 : 8'h0c, v[61], v[62], !v[62]});
	endtask
	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		repeat (60000) @(posedge core_clk_in);
		err_total++;
		wrap_up;
	end
	initial begin
		repeat (4) @(posedge core_clk_in);
		reset_in <= 1'b0;
		apb(1'b0, `OFS_CTRL, 32'h0);
		chk(rq, `CTRL_RESET);
		apb(1'b1, `OFS_CTRL, 32'h20);
		apb(1'b0, `OFS_STATUS, 32'h0);
		chk(rq, 32'h1);
		apb(1'b1, `OFS_CMD, 32'h23);
		@(negedge core_clk_in);
		chk(serial_mgmt_ready_out, 1'b1);
		apb(1'b0, 8'h1c, 32'h0);
		chk({re, rq}, 33'h1_0000_0000);
		apb(1'b1, `OFS_CTRL, 32'h27);
		apb(1'b0, `OFS_CTRL, 32'h0);
		chk(rq, 32'h27);
		mcmd(2'h1, 5'h01, 5'h03, 16'hbeef);
		mcmd(2'h2, 5'h01, 5'h03, 16'h0);
		apb(1'b0, `OFS_RDATA, 32'h0);
		chk(rq, 32'hbeef);
		mcmd(2'h2, 5'h02, 5'h03, 16'h0);
		apb(1'b0, `OFS_RDATA, 32'h0);
		chk(rq, 32'hffff);
		mcmd(2'h0, 5'h01, 5'h1f, 16'h0);
		mcmd(2'h3, 5'h1f, 5'h00, 16'h0);
		@(posedge core_clk_in);
		rx_frame_busy_in <= 1'b1;
		tx_frame_busy_in <= 1'b1;
		config_vector_in <= V1;
		repeat (6) @(posedge core_clk_in);
		cfg_chk(V1 & `CFG_NOW_MASK);
		rx_frame_busy_in <= 1'b0;
		tx_frame_busy_in <= 1'b0;
		repeat (6) @(posedge core_clk_in);
		cfg_chk(V1);
		rx_frame_busy_in <= 1'b1;
		config_vector_in <= V2;
		repeat (6) @(posedge core_clk_in);
		cfg_chk((V2 & ~`CFG_RX_MASK) | (V1 & `CFG_RX_MASK));
		rx_frame_busy_in <= 1'b0;
		repeat (6) @(posedge core_clk_in);
		cfg_chk(V2);
		pause_req_in <= 1'b0;
		rx_pause_frame_in <= 1'b0;
		repeat (3) @(posedge core_clk_in);
		chk({tx_pause_send_out, rx_pause_inhibit_out, rx_pause_to_client_out}, 3'h0);
		wrap_up;
	end
endmodule // mgmt_front_test

// ==== tb/phy_model.sv ====
`timescale 1ns/10ps
module phy_model #(
	parameter [4:0] PHY_ADR = 5'h01
) (
	// Serial pins
	input  wire        mdc_in,
	input  wire        pin_d_in,
	input  wire        pin_oe_n_in,
	output wire        pin_out,
	// Last header seen
	output reg  [11:0] hdr_out
);
	reg [5:0]  ones = 6'h0;
	reg [5:0]  pos  = 6'h0;
	reg        act  = 1'b0;
	reg        drv  = 1'b0;
	reg        dbit = 1'b1;
	reg [15:0] sh;
	reg [15:0] mem [0:31];
	wire       rd = hdr_out[11:10] == 2'h2 && hdr_out[9:5] == PHY_ADR;
	// Pull-up: a released line reads one
	assign pin_out = !pin_oe_n_in ? pin_d_in : (drv ? dbit : 1'b1);
	always @(posedge mdc_in) begin
		if (!act) begin
			if (!pin_out && ones >= 6'h20) begin
				act <= 1'b1;
				pos <= 6'h21;
			end
			ones <= pin_out ? ones + {5'h0, ones != 6'h3f} : 6'h0;
		end else begin
			sh <= {sh[14:0], pin_out};
			pos <= pos + 6'h1;
			if (pos == 6'h2d) hdr_out <= {sh[10:0], pin_out};
			if (pos == 6'h3f) begin
				act <= 1'b0;
				ones <= 6'h0;
				if (hdr_out[11:10] == 2'h1 && hdr_out[9:5] == PHY_ADR) mem[hdr_out[4:0]] <= {sh[14:0], pin_out};
			end
		end
	end
	// Turnaround zero, then data MSB first
	always @(negedge mdc_in) begin
		drv <= act && rd && pos >= 6'h2f;
		dbit <= pos == 6'h2f ? 1'b0 : mem[hdr_out[4:0]][6'h3f - pos];
	end
endmodule // phy_model
